// ### spl_pkg.sv
// constants for the sector protection and lock logic
package spl_pkg;
  localparam int          NUM_SECT       = 128;
  localparam int          SECT_W         = 7;
  localparam int          ADDR_W         = 24;
  localparam int          SECT_LSB       = 16;
  localparam logic [7:0]  OP_RD_PROT     = 8'h3C;
  localparam logic [7:0]  OP_WR_STAT1    = 8'h01;
  localparam logic [5:0]  BITS_OPCODE    = 6'h08;
  localparam logic [5:0]  BITS_WR_DONE   = 6'h10;
  localparam logic [5:0]  BITS_RD_START  = 6'h20;
  localparam logic [5:0]  BITS_SAT       = 6'h3F;
  localparam int          ST_LOCK_POS    = 7;
  localparam int          ST_PIN_POS     = 4;
  localparam int          ST_SUM_HI      = 3;
  localparam int          ST_SUM_LO      = 2;
  localparam int          GLB_HI         = 5;
  localparam int          GLB_LO         = 2;
  localparam logic [3:0]  GLB_UNPROT     = 4'h0;
  localparam logic [3:0]  GLB_PROT       = 4'hF;
  localparam logic [1:0]  SUM_NONE       = 2'h0;
  localparam logic [1:0]  SUM_SOME       = 2'h1;
  localparam logic [1:0]  SUM_ALL        = 2'h3;
  localparam logic [NUM_SECT-1:0] PROT_RST = {NUM_SECT{1'b1}};
  localparam logic        LOCK_RST       = 1'b0;
  localparam int          SYNC_STAGES    = 2;
  // synced pin levels at reset: {cs_n, sck, si, wp_n}, link idle
  localparam logic [3:0]  PINS_RST       = 4'h9;
endpackage

// ### spl_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module spl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // asynchronous level in, synchronous level out
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_ff <= rst_val_i; // idle pin levels, no false edge
      q_o     <= rst_val_i;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule

// ### spl_top.sv
// sector protection, lock bit and protection read over the serial link
`timescale 1ns/10ps
module spl_top (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  // serial link pins
  input  wire logic                    cs_n_i,
  input  wire logic                    sck_i,
  input  wire logic                    si_i,
  output logic                         so_o,
  output logic                         so_oe_o,
  // write protect pin
  input  wire logic                    wp_n_i,
  // sector protect/unprotect request from command logic
  input  wire logic                    sect_req_i,
  input  wire logic                    sect_set_i,
  input  wire logic [spl_pkg::SECT_W-1:0] sect_idx_i,
  // status
  output logic [7:0]                   status_byte1_o,
  output logic                         protect_regs_lock_bit_o,
  output logic [1:0]                   soft_protect_summary_o,
  output logic                         hw_locked_o,
  output logic                         sw_locked_o,
  output logic                         stat_wr_done_o
);
  logic [3:0]  pins_s;
  logic        cs_n_s;
  logic        sck_s;
  logic        si_s;
  logic        wp_n_s;
  logic        sck_d_ff;
  logic        sck_rise;
  logic        sck_fall;
  logic [5:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  opcode_ff;
  logic [spl_pkg::ADDR_W-1:0] addr_ff;
  logic [7:0]  nxt_shift;
  logic        rd_act_ff;
  logic        lock_ff;
  logic [spl_pkg::NUM_SECT-1:0] prot_ff;
  logic        hw_lock;
  logic        sw_lock;
  logic        wr_fire;
  logic [7:0]  wr_data;
  logic        glb_unprot;
  logic        glb_prot;
  logic [1:0]  summary;
  logic        sel_prot;

  // pins enter through two flops
  spl_sync #(.W(4)) u_sync (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .d_i       ({cs_n_i, sck_i, si_i, wp_n_i}),
    .rst_val_i (spl_pkg::PINS_RST),
    .q_o       (pins_s)
  );
  assign cs_n_s = pins_s[3];
  assign sck_s  = pins_s[2];
  assign si_s   = pins_s[1];
  assign wp_n_s = pins_s[0];

  // serial clock edge finder
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_ff & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_ff & ~cs_n_s;

  // locking states from pin and lock bit
  assign hw_lock = ~wp_n_s & lock_ff;
  assign sw_lock = wp_n_s & lock_ff;

  // input shift and bit count, restarted by chip select
  assign nxt_shift = {shift_ff[6:0], si_s};
  always_ff @(posedge clk_i) begin
    if (!nrst_i || cs_n_s) begin
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else if (sck_rise) begin
      shift_ff <= nxt_shift;
      if (bit_cnt_ff != spl_pkg::BITS_SAT) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
    end
  end

  // opcode and address capture
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      opcode_ff <= '0;
      addr_ff   <= '0;
    end else if (sck_rise) begin
      if (bit_cnt_ff == spl_pkg::BITS_OPCODE - 6'h01) begin
        opcode_ff <= nxt_shift;
      end
      if (bit_cnt_ff >= spl_pkg::BITS_OPCODE &&
          bit_cnt_ff <  spl_pkg::BITS_RD_START) begin
        addr_ff <= {addr_ff[spl_pkg::ADDR_W-2:0], si_s};
      end
    end
  end

  // status byte one write fires on its eighth data bit
  assign wr_fire = sck_rise && opcode_ff == spl_pkg::OP_WR_STAT1 &&
                   bit_cnt_ff == spl_pkg::BITS_WR_DONE - 6'h01;
  assign wr_data = nxt_shift;
  // global operation only when unlocked before the write
  assign glb_unprot = wr_fire && !lock_ff &&
    wr_data[spl_pkg::GLB_HI:spl_pkg::GLB_LO] == spl_pkg::GLB_UNPROT;
  assign glb_prot = wr_fire && !lock_ff &&
    wr_data[spl_pkg::GLB_HI:spl_pkg::GLB_LO] == spl_pkg::GLB_PROT;

  // lock bit: only bit 7 of the written byte is stored
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lock_ff <= spl_pkg::LOCK_RST;
    end else if (wr_fire && !hw_lock) begin
      lock_ff <= wr_data[spl_pkg::ST_LOCK_POS];
    end
  end

  // sector protection bits
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prot_ff <= spl_pkg::PROT_RST;
    end else if (glb_unprot) begin
      prot_ff <= '0;
    end else if (glb_prot) begin
      prot_ff <= '1;
    end else if (sect_req_i && !lock_ff) begin
      prot_ff[sect_idx_i] <= sect_set_i;
    end
  end
  // locked writes fall through above with no global change

  // protection summary over all sectors
  always_comb begin
    if (&prot_ff) begin
      summary = spl_pkg::SUM_ALL;
    end else if (|prot_ff) begin
      summary = spl_pkg::SUM_SOME;
    end else begin
      summary = spl_pkg::SUM_NONE;
    end
  end

  // addressed sector from upper address bits
  assign sel_prot =
    prot_ff[addr_ff[spl_pkg::SECT_LSB +: spl_pkg::SECT_W]];

  // protection read: drive on falling edges after the address
  always_ff @(posedge clk_i) begin
    if (!nrst_i || cs_n_s) begin
      rd_act_ff <= 1'b0;
      so_o      <= 1'b0;
      so_oe_o   <= 1'b0;
    end else if (sck_fall && opcode_ff == spl_pkg::OP_RD_PROT &&
                 bit_cnt_ff >= spl_pkg::BITS_RD_START) begin
      rd_act_ff <= 1'b1;
      so_o      <= sel_prot;
      so_oe_o   <= 1'b1;
    end
  end

  // registered status outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      status_byte1_o          <= '0;
      protect_regs_lock_bit_o <= 1'b0;
      soft_protect_summary_o  <= '0;
      hw_locked_o             <= 1'b0;
      sw_locked_o             <= 1'b0;
      stat_wr_done_o          <= 1'b0;
    end else begin
      status_byte1_o <= '0;
      status_byte1_o[spl_pkg::ST_LOCK_POS] <= lock_ff;
      status_byte1_o[spl_pkg::ST_PIN_POS]  <= wp_n_s;
      status_byte1_o[spl_pkg::ST_SUM_HI:spl_pkg::ST_SUM_LO] <=
        summary;
      protect_regs_lock_bit_o <= lock_ff;
      soft_protect_summary_o  <= summary;
      hw_locked_o             <= hw_lock;
      sw_locked_o             <= sw_lock;
      stat_wr_done_o          <= wr_fire;
    end
  end
endmodule

// ### spl_top_chk.sv
// assertion checker for the sector protection and lock logic
`timescale 1ns/10ps
module spl_top_chk (
  // watched ports of the top module
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       cs_n_i,
  input wire logic       so_oe_o,
  input wire logic [7:0] status_byte1_o,
  input wire logic       protect_regs_lock_bit_o,
  input wire logic [1:0] soft_protect_summary_o,
  input wire logic       hw_locked_o,
  input wire logic       sw_locked_o,
  input wire logic       stat_wr_done_o
);
  wire lk = protect_regs_lock_bit_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // locking states, status layout and link release
  property p_hw; hw_locked_o |-> lk && !sw_locked_o; endproperty
  a_hw: assert property (p_hw) else $error("hw lock bad");
  property p_frz;
    hw_locked_o [*3] |-> $stable(lk) && $stable(soft_protect_summary_o);
  endproperty
  a_frz: assert property (p_frz) else $error("frozen changed");
  property p_chg; $changed(lk) |-> $past(stat_wr_done_o); endproperty
  a_chg: assert property (p_chg) else $error("lock moved");
  property p_pls; stat_wr_done_o |=> !stat_wr_done_o; endproperty
  a_pls: assert property (p_pls) else $error("done too long");
  property p_zer; (status_byte1_o & 8'h63) == 8'h00; endproperty
  a_zer: assert property (p_zer) else $error("status bits");
  property p_sum; soft_protect_summary_o != 2'h2; endproperty
  a_sum: assert property (p_sum) else $error("summary code");
  property p_oe; cs_n_i [*5] |-> !so_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("so not released");
  property p_rst; $rose(nrst_i) |-> !lk; endproperty
  a_rst: assert property (p_rst) else $error("lock at reset");
  // main scenarios reached
  c_hw: cover property (hw_locked_o);
  c_sw: cover property (sw_locked_o);
  c_rd: cover property ($rose(so_oe_o));
endmodule

bind spl_top spl_top_chk spl_top_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i),
  .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .status_byte1_o(status_byte1_o),
  .protect_regs_lock_bit_o(protect_regs_lock_bit_o),
  .soft_protect_summary_o(soft_protect_summary_o),
  .hw_locked_o(hw_locked_o), .sw_locked_o(sw_locked_o),
  .stat_wr_done_o(stat_wr_done_o));

// ### spl_host.sv
// serial host model driving chip select, clock and data
`timescale 1ns/10ps
module spl_host (
  // link pins
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  // a released output reads as a changing pattern, never as the old bit
  wire so_w = so_oe_i ? so_i : ~si_o;
  // idle link: deselected, clock stands low
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // one frame of n bits from d msb first, mode 0; r keeps last 8 in
  task automatic frame(input logic [47:0] d, input int n,
                       output logic [7:0] r);
    cs_n_o = 1'b0;
    for (int i = 47; i > 47 - n; i--) begin
      si_o = d[i];
      #62.5 sck_o = 1'b1;
      r = {r[6:0], so_w};
      #62.5 sck_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
    #250;
  endtask
endmodule

// ### test_spl_top.sv
// self-checking bench for the sector protection and lock logic
`timescale 1ns/10ps
module test_spl_top;
  logic                         clk_i, nrst_i, wp_n_i, sect_req_i;
  logic                         sect_set_i, cs_n, sck, si, so, so_oe;
  logic                         lock, hw, sw, done;
  logic [spl_pkg::SECT_W-1:0]   sect_idx_i;
  logic [7:0]                   st, r;
  logic [1:0]                   sum;
  int                           err_count = 0;
  int                           checks = 0;
  int                           done_cnt = 0;
  spl_top spl_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n_i),
    .sect_req_i(sect_req_i), .sect_set_i(sect_set_i),
    .sect_idx_i(sect_idx_i), .status_byte1_o(st),
    .protect_regs_lock_bit_o(lock), .soft_protect_summary_o(sum),
    .hw_locked_o(hw), .sw_locked_o(sw), .stat_wr_done_o(done));
  spl_host spl_host_inst (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .so_i(so), .so_oe_i(so_oe));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // count status write pulses
  always @(posedge clk_i) begin
    if (done === 1'b1) begin
      done_cnt++;
    end
  end
  // compare any byte result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // status byte and locking flags against lock, pin and summary
  task automatic st_is(input logic l, input logic [1:0] s);
    chk(st, {l, 2'h0, wp_n_i, s, 2'h0});
    chk({5'h0, lock, sum}, {5'h0, l, s});
    chk({6'h0, hw, sw}, {6'h0, l & ~wp_n_i, l & wp_n_i});
  endtask
  // status write and protection read frames, started off the clock edge
  task automatic wr(input logic [7:0] v);
    int n0;
    n0 = done_cnt;
    @(posedge clk_i);
    #1;
    spl_host_inst.frame({spl_pkg::OP_WR_STAT1, v, 32'h0}, 16, r);
    chk(8'(done_cnt - n0), 8'h01);
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1;
    spl_host_inst.frame({spl_pkg::OP_RD_PROT, a, 16'h0}, 48, r);
    chk(r, exp);
  endtask
  // one-cycle sector request
  task automatic sreq(input logic v, input logic [6:0] i);
    @(posedge clk_i) #1 sect_req_i = 1'b1;
    sect_set_i = v;
    sect_idx_i = i;
    @(posedge clk_i) #1 sect_req_i = 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // verdict and end of run
  task automatic end_of_test;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
  // test sequence
  initial begin
    {nrst_i, sect_req_i, sect_set_i, sect_idx_i} = '0;
    wp_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    st_is(1'b0, 2'h3);
    rd(24'h05_1234, 8'hFF);
    wr(8'h00); st_is(1'b0, 2'h0);
    rd(24'h05_0000, 8'h00);
    sreq(1'b1, 7'h03); st_is(1'b0, 2'h1);
    rd(24'h03_FFFF, 8'hFF);
    rd(24'h04_0000, 8'h00);
    wr(8'h7F); st_is(1'b0, 2'h3);
    wr(8'hF0); st_is(1'b1, 2'h3);
    sreq(1'b0, 7'h03); st_is(1'b1, 2'h3);
    wr(8'h00); st_is(1'b0, 2'h3);
    wr(8'h80); st_is(1'b1, 2'h0);
    wr(8'h0F); st_is(1'b0, 2'h0);
    wr(8'hFF); st_is(1'b1, 2'h3);
    @(posedge clk_i) #1 wp_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    st_is(1'b1, 2'h3);
    wr(8'h0F); st_is(1'b1, 2'h3);
    sreq(1'b0, 7'h07); st_is(1'b1, 2'h3);
    @(posedge clk_i);
    #1 spl_host_inst.frame({spl_pkg::OP_RD_PROT, 40'h0}, 44, r);
    chk(r, 8'hFF);
    chk({7'h0, so_oe}, 8'h00);
    @(posedge clk_i) #1 nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    st_is(1'b0, 2'h3);
    end_of_test;
  end
endmodule
